// file: include/sdrlp_pkg.sv
// Shared constants and types of the SDRAM controller local port.
// Assumes one 100 MHz user clock shared by the master and the controller.
package sdrlp_pkg;

    // ==========================================================
    // Rate and widths
    // ==========================================================
    localparam int HALF_RATE = 0;
    localparam int RATE_DROP = (HALF_RATE != 0) ? 2 : 1;
    localparam int MEM_DQ_W = 16;
    localparam int LOCAL_DW = MEM_DQ_W * (1 << RATE_DROP);
    localparam int BE_W = LOCAL_DW / 8;
    localparam int CHIP_BITS = 1;
    localparam int CS_W = 1 << CHIP_BITS;
    localparam int ROW_BITS = 13;
    localparam int BANK_BITS = 2;
    localparam int COL_BITS = 10;
    localparam int ADDR_W = CHIP_BITS + ROW_BITS + BANK_BITS + COL_BITS
        - RATE_DROP;
    localparam int MAX_BURST = 64;
    localparam int SIZE_W = $clog2(MAX_BURST) + 1;
    localparam int QUEUE_DEPTH = 8;
    localparam int QCNT_W = $clog2(QUEUE_DEPTH) + 1;
    localparam int QPTR_W = $clog2(QUEUE_DEPTH);

    // ==========================================================
    // Build options
    // ==========================================================
    typedef enum logic {SDRLP_ORD_RBC, SDRLP_ORD_BRC} sdrlp_order_t;
    localparam sdrlp_order_t ADDR_ORDER = SDRLP_ORD_RBC;
    localparam bit USER_REFRESH = 1'b1;
    localparam bit ECC_EN = 1'b1;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_MHZ = 100;
    localparam int REFI_NS = 7800;
    localparam int REFI_CYC = REFI_NS * CLK_MHZ / 1000;
    localparam int RFC_NS = 130;
    localparam int RFC_CYC = (RFC_NS * CLK_MHZ + 999) / 1000;
    localparam int XS_NS = 140;
    localparam int XS_CYC = (XS_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W = 10;

    // ==========================================================
    // Memory-side commands
    // ==========================================================
    typedef enum logic [2:0] {
        SDRLP_MC_NOP, SDRLP_MC_READ, SDRLP_MC_WRITE, SDRLP_MC_REFRESH,
        SDRLP_MC_SR_ENTER, SDRLP_MC_SR_EXIT
    } sdrlp_mcmd_t;

endpackage : sdrlp_pkg

// file: include/sdrlp_if.sv
// Local port between the user master and the SDRAM controller.
// Assumes both ends share the clock and reset given to them directly.
`timescale 1ns/100ps
interface sdrlp_if;
    import sdrlp_pkg::*;

    logic writeReq;
    logic readReq;
    logic burstBegin;
    logic [ADDR_W-1:0] addr;
    logic [SIZE_W-1:0] size;
    logic [LOCAL_DW-1:0] wdata;
    logic [BE_W-1:0] byteLaneEnables;
    logic autoPchReq;
    logic refreshReq;
    logic [CS_W-1:0] refreshChip;
    logic selfRfshReq;
    logic [CS_W-1:0] selfRfshChip;
    logic ready;
    logic refreshAck;
    logic selfRfshAck;
    logic initDone;
    logic [LOCAL_DW-1:0] rdata;
    logic rdataValid;
    logic rdataError;

    modport dev(
        input writeReq, readReq, burstBegin, addr, size, wdata,
        input byteLaneEnables, autoPchReq, refreshReq, refreshChip,
        input selfRfshReq, selfRfshChip,
        output ready, refreshAck, selfRfshAck, initDone,
        output rdata, rdataValid, rdataError
    );
    modport host(
        output writeReq, readReq, burstBegin, addr, size, wdata,
        output byteLaneEnables, autoPchReq, refreshReq, refreshChip,
        output selfRfshReq, selfRfshChip,
        input ready, refreshAck, selfRfshAck, initDone,
        input rdata, rdataValid, rdataError
    );
endinterface : sdrlp_if

// file: logic/sdrlp_addr_map.sv
// Splits a local word address into chip, row, bank and column fields.
// Assumes a combinational use inside the controller.
`timescale 1ns/100ps
module sdrlp_addr_map
    import sdrlp_pkg::*;
(
    input wire logic [ADDR_W-1:0] localAddr,
    output logic [CHIP_BITS-1:0] chip,
    output logic [ROW_BITS-1:0] row,
    output logic [BANK_BITS-1:0] bank,
    output logic [COL_BITS-1:0] col
);
    logic [COL_BITS-RATE_DROP-1:0] colHi;

    always_comb begin
        if (ADDR_ORDER == SDRLP_ORD_RBC) begin
            {chip, row, bank, colHi} = localAddr;
        end else begin
            {chip, bank, row, colHi} = localAddr;
        end
        // Each local word spans several memory words, so low bits are 0.
        col = {colHi, {RATE_DROP{1'b0}}};
    end
endmodule : sdrlp_addr_map

// file: logic/sdrlp_ctrl.sv
// SDRAM controller end of the local port: request queue, scheduler,
// refresh, self-refresh and read return.
// Assumes a physical layer on the same clock that executes one memory
// command per cycle and returns read words in request order.
// Behaviour
// - Full rate: address drops one column bit.
// - Half rate: address drops two column bits.
// - Row above bank above column by default.
// - Data mask is inverse of byte enables.
// - Local data twice or four times memory.
// - Master pulses burst start once per write.
// - Master holds write signals while not ready.
// - Master pulses start with read, holds read.
// - Burst start sampled only with write request.
// - Never read and write together.
// - No requests before reset release.
// - Pending refresh precedes queued accesses.
// - Refresh only ranks with mask set.
// - Beat count one to sixty-four, binary.
// - Auto-precharge request gives precharging access.
// - Self-refresh held while requested, acknowledged.
// - Self-refresh only ranks with mask set.
// - Init-done flag follows sequencer completion.
// - Requests accepted early, issued after ready.
// - Error flag rides with read valid.
// - Read valid exactly with returned data.
// - Accept when ready; eight requests buffered.
// - One-cycle pulse per issued refresh.
//
`timescale 1ns/100ps
module sdrlp_ctrl
    import sdrlp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    sdrlp_if.dev bus,
    input wire logic seqReady,
    input wire logic [LOCAL_DW-1:0] memRdata,
    input wire logic memRdValid,
    input wire logic memRdError,
    output sdrlp_mcmd_t memCmd,
    output logic [CHIP_BITS-1:0] memChip,
    output logic [ROW_BITS-1:0] memRow,
    output logic [BANK_BITS-1:0] memBank,
    output logic [COL_BITS-1:0] memCol,
    output logic memAutoPch,
    output logic [LOCAL_DW-1:0] memWdata,
    output logic [BE_W-1:0] memoryDataMask,
    output logic [CS_W-1:0] memRankMask
);
    // ==========================================================
    // Types and state
    // ==========================================================
    typedef enum logic [2:0] {
        SDRLP_S_INIT, SDRLP_S_IDLE, SDRLP_S_READ, SDRLP_S_SELF, SDRLP_S_SRX
    } sdrlp_dstate_t;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [SIZE_W-1:0] size;
        logic [LOCAL_DW-1:0] data;
        logic [BE_W-1:0] be;
        logic autoPch;
    } sdrlp_req_t;

    typedef struct packed {
        sdrlp_req_t [QUEUE_DEPTH-1:0] q;
        logic [QPTR_W-1:0] head;
        logic [QPTR_W-1:0] tail;
        logic [QCNT_W-1:0] count;
        logic ready;
        logic [ADDR_W-1:0] wBase;
        logic [SIZE_W-1:0] wBeat;
        sdrlp_dstate_t fsm;
        sdrlp_req_t cur;
        logic [SIZE_W-1:0] beat;
        logic [TMR_W-1:0] tmr;
        logic [TMR_W-1:0] refiCnt;
        logic refPending;
        logic initDone;
        logic [LOCAL_DW-1:0] rdata;
        logic rdValid;
        logic rdError;
        logic refAck;
        logic srAck;
        sdrlp_mcmd_t memCmd;
        logic [CHIP_BITS-1:0] chip;
        logic [ROW_BITS-1:0] row;
        logic [BANK_BITS-1:0] bank;
        logic [COL_BITS-1:0] col;
        logic autoPch;
        logic [LOCAL_DW-1:0] wdata;
        logic [BE_W-1:0] dm;
        logic [CS_W-1:0] rank;
    } sdrlp_dstate_s_t;

    sdrlp_dstate_s_t s_r;
    sdrlp_dstate_s_t s_nxt;

    function automatic logic [ADDR_W-1:0] addrAdd(
        input logic [ADDR_W-1:0] base,
        input logic [SIZE_W-1:0] off
    );
        addrAdd = ADDR_W'(base + ADDR_W'(off));
    endfunction : addrAdd

    // ==========================================================
    // Address mapping
    // ==========================================================
    sdrlp_req_t headReq;
    logic [ADDR_W-1:0] mapAddr;
    logic [CHIP_BITS-1:0] mapChip;
    logic [ROW_BITS-1:0] mapRow;
    logic [BANK_BITS-1:0] mapBank;
    logic [COL_BITS-1:0] mapCol;

    assign headReq = s_r.q[s_r.head];
    assign mapAddr = (s_r.fsm == SDRLP_S_READ)
        ? addrAdd(s_r.cur.addr, s_r.beat) : headReq.addr;

    sdrlp_addr_map u_map (
        .localAddr(mapAddr),
        .chip(mapChip),
        .row(mapRow),
        .bank(mapBank),
        .col(mapCol)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    logic push;
    logic pop;
    logic refWant;
    logic [CS_W-1:0] refMask;
    sdrlp_req_t newReq;

    always_comb begin
        s_nxt = s_r;
        push = 1'b0;
        pop = 1'b0;
        newReq = '0;
        s_nxt.refAck = 1'b0;
        s_nxt.memCmd = SDRLP_MC_NOP;
        s_nxt.autoPch = 1'b0;
        s_nxt.initDone = s_r.initDone | seqReady;

        // Read return straight from the physical layer.
        s_nxt.rdValid = memRdValid;
        s_nxt.rdError = memRdValid & ECC_EN & memRdError;
        if (memRdValid) begin
            s_nxt.rdata = memRdata;
        end

        // Request intake; each write beat becomes one queue entry.
        if (s_r.ready && (bus.writeReq || bus.readReq)) begin
            push = 1'b1;
            newReq.write = bus.writeReq;
            newReq.data = bus.wdata;
            newReq.be = bus.byteLaneEnables;
            newReq.autoPch = bus.autoPchReq;
            if (bus.writeReq) begin
                newReq.size = SIZE_W'(1);
                if (bus.burstBegin) begin
                    newReq.addr = bus.addr;
                    s_nxt.wBase = bus.addr;
                    s_nxt.wBeat = SIZE_W'(1);
                end else begin
                    newReq.addr = addrAdd(s_r.wBase, s_r.wBeat);
                    s_nxt.wBeat = SIZE_W'(s_r.wBeat + 1'b1);
                end
            end else begin
                newReq.addr = bus.addr;
                newReq.size = bus.size;
            end
            s_nxt.q[s_r.tail] = newReq;
            s_nxt.tail = QPTR_W'(s_r.tail + 1'b1);
        end

        // Refresh source: user level, or the internal interval timer.
        if (!USER_REFRESH) begin
            if (s_r.refiCnt == '0) begin
                s_nxt.refiCnt = TMR_W'(REFI_CYC - 1);
                s_nxt.refPending = 1'b1;
            end else begin
                s_nxt.refiCnt = TMR_W'(s_r.refiCnt - 1'b1);
            end
        end
        refWant = USER_REFRESH ? bus.refreshReq : s_r.refPending;
        refMask = USER_REFRESH ? bus.refreshChip : {CS_W{1'b1}};
        if (s_r.tmr != '0) begin
            s_nxt.tmr = TMR_W'(s_r.tmr - 1'b1);
        end

        case (s_r.fsm)
            SDRLP_S_INIT: begin
                if (s_r.initDone) begin
                    s_nxt.fsm = SDRLP_S_IDLE;
                end
            end
            SDRLP_S_IDLE: begin
                if (s_r.tmr != '0) begin
                    s_nxt.fsm = SDRLP_S_IDLE;
                end else if (bus.selfRfshReq) begin
                    s_nxt.memCmd = SDRLP_MC_SR_ENTER;
                    s_nxt.rank = bus.selfRfshChip;
                    s_nxt.srAck = 1'b1;
                    s_nxt.fsm = SDRLP_S_SELF;
                end else if (refWant) begin
                    s_nxt.memCmd = SDRLP_MC_REFRESH;
                    s_nxt.rank = refMask;
                    s_nxt.refAck = 1'b1;
                    s_nxt.refPending = 1'b0;
                    s_nxt.tmr = TMR_W'(RFC_CYC);
                end else if (s_r.count != '0) begin
                    pop = 1'b1;
                    if (headReq.write) begin
                        s_nxt.memCmd = SDRLP_MC_WRITE;
                        s_nxt.chip = mapChip;
                        s_nxt.row = mapRow;
                        s_nxt.bank = mapBank;
                        s_nxt.col = mapCol;
                        s_nxt.autoPch = headReq.autoPch;
                        s_nxt.wdata = headReq.data;
                        s_nxt.dm = ~headReq.be;
                        s_nxt.rank = CS_W'(1) << mapChip;
                    end else begin
                        s_nxt.cur = headReq;
                        s_nxt.beat = '0;
                        s_nxt.fsm = SDRLP_S_READ;
                    end
                end
            end
            SDRLP_S_READ: begin
                // A read in progress is never cut by a refresh.
                s_nxt.memCmd = SDRLP_MC_READ;
                s_nxt.chip = mapChip;
                s_nxt.row = mapRow;
                s_nxt.bank = mapBank;
                s_nxt.col = mapCol;
                s_nxt.rank = CS_W'(1) << mapChip;
                s_nxt.beat = SIZE_W'(s_r.beat + 1'b1);
                if (SIZE_W'(s_r.beat + 1'b1) >= s_r.cur.size) begin
                    s_nxt.autoPch = s_r.cur.autoPch;
                    s_nxt.fsm = SDRLP_S_IDLE;
                end
            end
            SDRLP_S_SELF: begin
                if (!bus.selfRfshReq) begin
                    s_nxt.memCmd = SDRLP_MC_SR_EXIT;
                    s_nxt.tmr = TMR_W'(XS_CYC);
                    s_nxt.fsm = SDRLP_S_SRX;
                end
            end
            SDRLP_S_SRX: begin
                if (s_r.tmr == '0) begin
                    s_nxt.srAck = 1'b0;
                    s_nxt.fsm = SDRLP_S_IDLE;
                end
            end
            default: begin
                s_nxt.fsm = SDRLP_S_INIT;
            end
        endcase

        if (pop) begin
            s_nxt.head = QPTR_W'(s_r.head + 1'b1);
        end
        s_nxt.count = QCNT_W'(s_r.count + QCNT_W'(push) - QCNT_W'(pop));
        s_nxt.ready = (s_nxt.count < QCNT_W'(QUEUE_DEPTH));
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign bus.ready = s_r.ready;
    assign bus.refreshAck = s_r.refAck;
    assign bus.selfRfshAck = s_r.srAck;
    assign bus.initDone = s_r.initDone;
    assign bus.rdata = s_r.rdata;
    assign bus.rdataValid = s_r.rdValid;
    assign bus.rdataError = s_r.rdError;
    assign memCmd = s_r.memCmd;
    assign memChip = s_r.chip;
    assign memRow = s_r.row;
    assign memBank = s_r.bank;
    assign memCol = s_r.col;
    assign memAutoPch = s_r.autoPch;
    assign memWdata = s_r.wdata;
    assign memoryDataMask = s_r.dm;
    assign memRankMask = s_r.rank;
endmodule : sdrlp_ctrl

// file: logic/sdrlp_master.sv
// User master end of the local port: turns user beats into held requests.
// Assumes the controller end is on the same clock and reset.
`timescale 1ns/100ps
module sdrlp_master
    import sdrlp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    sdrlp_if.host bus,
    input wire logic userValid,
    output logic userReady,
    input wire logic userWrite,
    input wire logic userFirst,
    input wire logic [ADDR_W-1:0] userAddr,
    input wire logic [SIZE_W-1:0] userSize,
    input wire logic [LOCAL_DW-1:0] userWdata,
    input wire logic [BE_W-1:0] userBe,
    input wire logic userAutoPch,
    input wire logic userRefreshReq,
    input wire logic [CS_W-1:0] userRefreshChip,
    input wire logic userSelfRfshReq,
    input wire logic [CS_W-1:0] userSelfRfshChip,
    output logic [LOCAL_DW-1:0] userRdata,
    output logic userRdataValid,
    output logic userRdataError,
    output logic userRefreshAck,
    output logic userSelfRfshAck,
    output logic userInitDone
);
    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic wr;
        logic rd;
        logic bb;
        logic [ADDR_W-1:0] addr;
        logic [SIZE_W-1:0] size;
        logic [LOCAL_DW-1:0] wdata;
        logic [BE_W-1:0] be;
        logic apch;
        logic refReq;
        logic [CS_W-1:0] refChip;
        logic srReq;
        logic [CS_W-1:0] srChip;
        logic [LOCAL_DW-1:0] rdata;
        logic rdv;
        logic rde;
        logic refAck;
        logic srAck;
        logic initDone;
        logic uReady;
        logic armed;
    } sdrlp_mstate_t;

    sdrlp_mstate_t s_r;
    sdrlp_mstate_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        // Nothing is requested in the first cycle after reset release.
        s_nxt.armed = 1'b1;
        s_nxt.bb = 1'b0;
        if ((s_r.wr || s_r.rd) && bus.ready) begin
            s_nxt.wr = 1'b0;
            s_nxt.rd = 1'b0;
            s_nxt.apch = 1'b0;
        end
        // A held request keeps every field but burst start until taken.
        if (userValid && s_r.uReady) begin
            s_nxt.wr = userWrite;
            s_nxt.rd = !userWrite;
            s_nxt.bb = userWrite ? userFirst : 1'b1;
            s_nxt.addr = userAddr;
            s_nxt.size = userSize;
            s_nxt.wdata = userWdata;
            s_nxt.be = userBe;
            s_nxt.apch = userAutoPch;
        end
        s_nxt.uReady = s_r.armed && !(s_nxt.wr || s_nxt.rd);
        s_nxt.refReq = userRefreshReq;
        s_nxt.refChip = userRefreshChip;
        s_nxt.srReq = userSelfRfshReq;
        s_nxt.srChip = userSelfRfshChip;
        s_nxt.rdata = bus.rdata;
        s_nxt.rdv = bus.rdataValid;
        s_nxt.rde = bus.rdataError;
        s_nxt.refAck = bus.refreshAck;
        s_nxt.srAck = bus.selfRfshAck;
        s_nxt.initDone = bus.initDone;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign bus.writeReq = s_r.wr;
    assign bus.readReq = s_r.rd;
    assign bus.burstBegin = s_r.bb;
    assign bus.addr = s_r.addr;
    assign bus.size = s_r.size;
    assign bus.wdata = s_r.wdata;
    assign bus.byteLaneEnables = s_r.be;
    assign bus.autoPchReq = s_r.apch;
    assign bus.refreshReq = s_r.refReq;
    assign bus.refreshChip = s_r.refChip;
    assign bus.selfRfshReq = s_r.srReq;
    assign bus.selfRfshChip = s_r.srChip;
    assign userReady = s_r.uReady;
    assign userRdata = s_r.rdata;
    assign userRdataValid = s_r.rdv;
    assign userRdataError = s_r.rde;
    assign userRefreshAck = s_r.refAck;
    assign userSelfRfshAck = s_r.srAck;
    assign userInitDone = s_r.initDone;
endmodule : sdrlp_master

// file: dv/sdrlp_sva.sv
// Assertions on the local port between master and controller.
// Assumes the interface signals on one clock with async low reset.
`timescale 1ns/100ps
module sdrlp_sva
    import sdrlp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic writeReq,
    input wire logic readReq,
    input wire logic burstBegin,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [SIZE_W-1:0] size,
    input wire logic [LOCAL_DW-1:0] wdata,
    input wire logic [BE_W-1:0] byteLaneEnables,
    input wire logic ready,
    input wire logic refreshAck,
    input wire logic selfRfshReq,
    input wire logic selfRfshAck,
    input wire logic initDone,
    input wire logic rdataValid,
    input wire logic rdataError
);
    // ==========================================================
    // Port timing
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_no_rd_wr: assert property (!(readReq && writeReq))
        else $error("read and write together");
    a_wr_hold: assert property (writeReq && !ready |=> writeReq
        && $stable(addr) && $stable(wdata)
        && $stable(byteLaneEnables) && $stable(size))
        else $error("write changed while stalled");
    a_rd_hold: assert property (readReq && !ready |=> readReq
        && $stable(addr) && $stable(size))
        else $error("read changed while stalled");
    a_begin_once: assert property (burstBegin |=> !burstBegin)
        else $error("burst start longer than one cycle");
    a_size_legal: assert property (burstBegin |-> size >= 7'h01
        && size <= 7'h40)
        else $error("beat count out of range");
    a_err_valid: assert property (rdataError |-> rdataValid)
        else $error("error flag without valid");
    a_rfsh_pulse: assert property (refreshAck |=> !refreshAck[*8])
        else $error("refresh pulse too long");
    a_init_stays: assert property (initDone |=> initDone)
        else $error("init flag dropped");
    a_sr_hold: assert property (selfRfshReq && selfRfshAck |=>
        selfRfshAck)
        else $error("self-refresh ack dropped early");
endmodule : sdrlp_sva

// file: dv/sdrlp_tb.sv
// Bench joining master and controller over the local port.
// Assumes the bench plays user logic and the physical layer.
`timescale 1ns/100ps
module sdrlp_tb
    import sdrlp_pkg::*;
;
    logic clk = 0, nrst = 0, seqReady = 0, memRdValid = 0, memRdError = 0;
    logic userValid = 0, userWrite = 0, userAutoPch = 0;
    logic userRefreshReq = 0, userSelfRfshReq = 0;
    logic [ADDR_W-1:0] userAddr = '0;
    logic [SIZE_W-1:0] userSize = '0;
    logic [LOCAL_DW-1:0] userWdata = '0, memRdata = '0;
    logic [BE_W-1:0] userBe = '0;
    logic [CS_W-1:0] userRefreshChip = '0, userSelfRfshChip = '0;
    logic userReady, userRdataValid, userRdataError, memChip, memAutoPch;
    logic [LOCAL_DW-1:0] userRdata, memWdata;
    logic [ROW_BITS-1:0] memRow;
    logic [BANK_BITS-1:0] memBank;
    logic [COL_BITS-1:0] memCol;
    logic [BE_W-1:0] memoryDataMask;
    logic [CS_W-1:0] memRankMask;
    sdrlp_mcmd_t memCmd;
    int fails = 0, compares = 0, cycles = 0;
    logic userRefreshAck, userSelfRfshAck, userInitDone;
    always #5 clk = ~clk;
    sdrlp_if bus();
    sdrlp_ctrl i_sdrlp_ctrl(.clk(clk), .nrst(nrst), .ce(1'b1), .bus(bus),
        .seqReady(seqReady), .memRdata(memRdata), .memRdValid(memRdValid),
        .memRdError(memRdError), .memCmd(memCmd), .memChip(memChip),
        .memRow(memRow), .memBank(memBank), .memCol(memCol),
        .memAutoPch(memAutoPch), .memWdata(memWdata),
        .memoryDataMask(memoryDataMask), .memRankMask(memRankMask));
    sdrlp_master i_sdrlp_master(.clk(clk), .nrst(nrst), .ce(1'b1),
        .bus(bus), .userValid(userValid), .userReady(userReady),
        .userWrite(userWrite), .userFirst(1'b1), .userAddr(userAddr),
        .userSize(userSize), .userWdata(userWdata), .userBe(userBe),
        .userAutoPch(userAutoPch), .userRefreshReq(userRefreshReq),
        .userRefreshChip(userRefreshChip), .userSelfRfshReq(userSelfRfshReq),
        .userSelfRfshChip(userSelfRfshChip), .userRdata(userRdata),
        .userRdataValid(userRdataValid), .userRdataError(userRdataError),
        .userRefreshAck(userRefreshAck), .userSelfRfshAck(userSelfRfshAck),
        .userInitDone(userInitDone));
    sdrlp_sva i_sdrlp_sva(.clk(clk), .nrst(nrst), .writeReq(bus.writeReq),
        .readReq(bus.readReq), .burstBegin(bus.burstBegin), .addr(bus.addr),
        .size(bus.size), .wdata(bus.wdata),
        .byteLaneEnables(bus.byteLaneEnables), .ready(bus.ready),
        .refreshAck(bus.refreshAck), .selfRfshReq(bus.selfRfshReq),
        .selfRfshAck(bus.selfRfshAck), .initDone(bus.initDone),
        .rdataValid(bus.rdataValid), .rdataError(bus.rdataError));

    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    task automatic put(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [SIZE_W-1:0] s, input logic [BE_W-1:0] be,
        input logic ap);
        int n;
        n = 0;
        @(posedge clk);
        userValid <= 1'b1;
        userWrite <= wr;
        userAddr <= a;
        userSize <= s;
        userBe <= be;
        userAutoPch <= ap;
        userWdata <= ~{7'h00, a};
        @(posedge clk);
        while (userReady !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        userValid <= 1'b0;
    endtask : put
    task automatic wait_cmd(input sdrlp_mcmd_t c);
        int n;
        n = 0;
        @(negedge clk);
        while (memCmd !== c && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(memCmd, c);
    endtask : wait_cmd
    task automatic chk_addr(input logic [ADDR_W-1:0] a);
        chk(memChip, a[24]);
        chk(memRow, a[23:11]);
        chk(memBank, a[10:9]);
        chk(memCol, {a[8:0], 1'b0});
    endtask : chk_addr

    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_early;
        for (int i = 0; i < QUEUE_DEPTH; i++)
            put(1'b0, 25'h1a54200 + i * 3, 7'h01, 4'hf, 1'b0);
        repeat (4) @(negedge clk);
        chk(bus.ready, 1'b0);
        chk(memCmd, SDRLP_MC_NOP);
        @(posedge clk);
        seqReady <= 1'b1;
        for (int i = 0; i < QUEUE_DEPTH; i++) begin
            wait_cmd(SDRLP_MC_READ);
            chk_addr(25'h1a54200 + i * 3);
        end
        chk(bus.initDone, 1'b1);
        chk(userInitDone, 1'b1);
        $display("early requests test done");
    endtask : t_early
    task automatic t_write;
        for (int k = 0; k < BE_W; k++) begin
            put(1'b1, 25'h0b3c1f5 + k, 7'h01, ~(4'h1 << k), 1'b0);
            wait_cmd(SDRLP_MC_WRITE);
            chk_addr(25'h0b3c1f5 + k);
            chk(memoryDataMask, 4'h1 << k);
            chk(memWdata, ~{7'h00, 25'h0b3c1f5 + k});
        end
        $display("write mask test done");
    endtask : t_write
    task automatic t_burst;
        int n;
        put(1'b0, 25'h0e0a110, 7'h03, 4'hf, 1'b1);
        for (int k = 0; k < 3; k++) begin
            wait_cmd(SDRLP_MC_READ);
            chk_addr(25'h0e0a110 + k);
            chk(memAutoPch, k == 2);
        end
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            memRdValid <= 1'b1;
            memRdata <= 32'hc0de0000 + k;
            memRdError <= (k == 1);
            @(posedge clk);
            memRdValid <= 1'b0;
            n = 0;
            while (userRdataValid !== 1'b1 && n < 20) begin
                @(negedge clk);
                n++;
            end
            chk(userRdata, 32'hc0de0000 + k);
            chk(userRdataError, k == 1);
            @(negedge clk);
            chk(userRdataValid, 1'b0);
        end
        $display("burst read test done");
    endtask : t_burst

    task automatic t_power;
        @(posedge clk);
        userRefreshChip <= 2'h2;
        userRefreshReq <= 1'b1;
        wait_cmd(SDRLP_MC_REFRESH);
        chk(memRankMask, 2'h2);
        chk(bus.refreshAck, 1'b1);
        @(negedge clk);
        chk(userRefreshAck, 1'b1);
        @(posedge clk);
        userRefreshReq <= 1'b0;
        userSelfRfshChip <= 2'h1;
        userSelfRfshReq <= 1'b1;
        wait_cmd(SDRLP_MC_SR_ENTER);
        chk(memRankMask, 2'h1);
        repeat (5) @(negedge clk);
        chk(bus.selfRfshAck, 1'b1);
        chk(userSelfRfshAck, 1'b1);
        @(posedge clk);
        userSelfRfshReq <= 1'b0;
        wait_cmd(SDRLP_MC_SR_EXIT);
        repeat (XS_CYC + 3) @(negedge clk);
        chk(bus.selfRfshAck, 1'b0);
        $display("refresh test done");
    endtask : t_power

    // ==========================================================
    // Main sequence and hang guard
    // ==========================================================
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_early();
        t_write();
        t_burst();
        t_power();
        give_verdict();
    end
endmodule : sdrlp_tb
